/* hdl/i2c_target_pkg.sv */
// Shared constants and carrier types for the I2C register-access target.
// Assumes a 100 MHz core clock and classic Wishbone software access.
package i2c_target_pkg;
  localparam logic [6:0] ADDR_BASE = 7'h08;
  // Low byte of 0x11D; the x^8 term is implicit in the shift
  localparam logic [7:0] CRC_POLY = 8'h1d;
  localparam logic [7:0] CRC_INIT = 8'hff;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0c;
  localparam logic [7:0] OFS_FILE = 8'h40;
  localparam int CTRL_CRC_EN = 0;
  localparam int CTRL_ADDR_LSB = 4;
  localparam int ADDR_FIELD_W = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int STATUS_W = 2;
  localparam int ST_CRC_FAULT = 0;
  localparam int ST_WRITE_DONE = 1;
  localparam logic [STATUS_W-1:0] MASK_RESET = 2'h0;
  localparam int CLK_HZ = 100000000;
  localparam int SCL_MAX_HZ = 3400000;
  localparam int SCL_MIN_CYC = (CLK_HZ + SCL_MAX_HZ - 1) / SCL_MAX_HZ;
  localparam int SCL_CYC_NEEDED = 8;
  typedef struct packed {
    logic [7:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
  } wb_req_t;
  typedef struct packed {
    logic scl;
    logic sda;
  } i2c_pins_t;
endpackage

/* hdl/sync2.sv */
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level; no bus coherency is given.
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* hdl/crc8_byte.sv */
// One-byte update of an MSB-first CRC-8, purely combinational.
// Assumes the caller holds the running value and the preset.
`timescale 1ns/1ns
`default_nettype none
module crc8_byte #(
  parameter logic [7:0] POLY = 8'h1d
) (
  input wire logic [7:0] crcIn,
  input wire logic [7:0] data,
  output logic [7:0] crcOut
);
  always_comb begin
    logic [7:0] c;
    c = crcIn ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ POLY) : (c << 1);
    end
    crcOut = c;
  end
endmodule
`default_nettype wire

/* hdl/i2c_target_crc.sv */
// I2C target with CRC-8 checked writes, programming-mode override and
// a Wishbone register window. Assumes SCL/SDA and mode pins are async.
// Contract
// RULE_01: Device only ever acts as target; never drives SCL or starts transfers.
// RULE_02: Target address is 0x08 plus the 3-bit configured address field.
// RULE_03: Serial clock up to 3.4 MHz must be handled; controller stays below.
// RULE_04: A byte is taken only on its eighth bit; shorter tails are dropped.
// RULE_05: Seven-bit transfer writes nothing and gets no acknowledge.
// RULE_06: One control bit enables CRC checking when 1, disables when 0.
// RULE_07: With CRC enabled, a CRC byte is computed and compared per transaction.
// RULE_08: Mismatch drops the command, sets the CRC fault flag, interrupts if unmasked.
// RULE_09: CRC-8 polynomial 0x11D, preset 0xFF; controller computes it alike.
// RULE_10: Programming-mode pin low means normal, high means programming mode.
// RULE_11: In programming mode the target answers at fixed address 0x08.
// RULE_12: Programming mode without power-up event bypasses CRC and secure write.
// RULE_13: Programming mode tells the watchdog logic to stop entirely.
// RULE_14: Interrupt holds until software writes 1 to the flag, then releases.
// RULE_15: With CRC, write holds until the trailing check byte over all bytes matches.
`timescale 1ns/1ns
`default_nettype none
module i2c_target_crc
  import i2c_target_pkg::*;
#(
  parameter int FILE_DEPTH = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire wb_req_t wbReq,
  output logic [31:0] wbDatR,
  output logic wbAck,
  input wire i2c_pins_t pinsIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic programmingModePin,
  input wire logic powerUpEvent,
  output logic irq,
  output logic interruptRequestN,
  output logic configurationProgrammingMode,
  output logic watchdogStop,
  output logic secureWriteBypass
);
  localparam int PW = $clog2(FILE_DEPTH);

  initial begin
    if (FILE_DEPTH < 2 || FILE_DEPTH > 16 || (1 << PW) != FILE_DEPTH) begin
      $error("FILE_DEPTH must be a power of two from 2 to 16");
    end
    if (SCL_MIN_CYC < SCL_CYC_NEEDED) begin
      $error("Core clock too slow to sample the fastest serial clock"); // RULE_03
    end
  end

  typedef enum {IDLE, RX, ACK, TX, TXACK, IGNORE} phase_t;

  logic [3:0] syncQ;
  logic sclQ, sdaQ, progMode, powerUp;
  logic sclD_r, sdaD_r;
  logic startDet, stopDet, sclRise, sclFall;
  phase_t state_r;
  logic [7:0] shift_r, tx_r, crc_r, ptr_r, data_r, crcNxt, crcSeed;
  logic [3:0] bitCnt_r;
  logic [2:0] byteIdx_r;
  logic rw_r, crcTxn_r, hostAck_r;
  logic wrStrobe_r, crcFail_r;
  logic [PW-1:0] wrAddr_r;
  logic [7:0] wrData_r;
  logic [7:0] regFile [FILE_DEPTH];
  logic [7:0] ctrl_r;
  logic [STATUS_W-1:0] status_r, mask_r;
  logic [6:0] devAddr;
  logic crcOn, bypass, byteDone, ackByte, wrNow, failNow;
  logic wbAccept;

  sync2 #(.WIDTH(4)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({pinsIn.scl, pinsIn.sda, programmingModePin, powerUpEvent}),
    .q(syncQ)
  );
  assign {sclQ, sdaQ, progMode, powerUp} = syncQ;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sclD_r <= 1'b1;
      sdaD_r <= 1'b1;
    end else begin
      sclD_r <= sclQ;
      sdaD_r <= sdaQ;
    end
  end
  assign startDet = sclQ && sclD_r && sdaD_r && !sdaQ;
  assign stopDet = sclQ && sclD_r && !sdaD_r && sdaQ;
  assign sclRise = sclQ && !sclD_r;
  assign sclFall = !sclQ && sclD_r;

  // Mode pin overrides
  assign bypass = progMode && !powerUp; // RULE_12
  assign crcOn = ctrl_r[CTRL_CRC_EN] && !bypass; // RULE_06
  assign devAddr = progMode ? ADDR_BASE : // RULE_11
    ADDR_BASE + {4'h0, ctrl_r[CTRL_ADDR_LSB +: ADDR_FIELD_W]}; // RULE_02

  always_ff @(posedge clk) begin
    if (!nrst) begin
      configurationProgrammingMode <= 1'b0;
      watchdogStop <= 1'b0;
      secureWriteBypass <= 1'b0;
    end else begin
      configurationProgrammingMode <= progMode; // RULE_10
      watchdogStop <= progMode; // RULE_13
      secureWriteBypass <= bypass; // RULE_12
    end
  end

  assign crcSeed = (byteIdx_r == 3'd0) ? CRC_INIT : crc_r; // RULE_09
  crc8_byte #(.POLY(CRC_POLY)) u_crc (
    .crcIn(crcSeed),
    .data(shift_r),
    .crcOut(crcNxt)
  );

  // A byte counts only once its eighth bit has been clocked in
  assign byteDone = sclFall && state_r == RX && bitCnt_r == 4'd8; // RULE_04

  always_comb begin
    ackByte = 1'b0;
    wrNow = 1'b0;
    failNow = 1'b0;
    if (byteIdx_r == 3'd0) begin
      ackByte = shift_r[7:1] == devAddr;
    end else if (byteIdx_r == 3'd1) begin
      ackByte = 1'b1;
    end else if (!crcTxn_r) begin
      ackByte = 1'b1;
      wrNow = 1'b1;
    end else if (byteIdx_r == 3'd2) begin
      ackByte = 1'b1;
    end else if (byteIdx_r == 3'd3) begin
      ackByte = 1'b1;
      wrNow = shift_r == crc_r; // RULE_07
      failNow = !wrNow; // RULE_08
    end
  end

  // Only SDA is ever driven, and only low; SCL is input only
  assign sdaOut = 1'b0; // RULE_01

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= IDLE;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      crc_r <= CRC_INIT;
      ptr_r <= 8'h00;
      data_r <= 8'h00;
      bitCnt_r <= 4'h0;
      byteIdx_r <= 3'h0;
      rw_r <= 1'b0;
      crcTxn_r <= 1'b0;
      hostAck_r <= 1'b0;
      sdaOe <= 1'b0;
      wrStrobe_r <= 1'b0;
      crcFail_r <= 1'b0;
      wrAddr_r <= '0;
      wrData_r <= 8'h00;
    end else begin
      wrStrobe_r <= 1'b0;
      crcFail_r <= 1'b0;
      if (startDet) begin
        state_r <= RX;
        bitCnt_r <= 4'h0;
        byteIdx_r <= 3'h0;
        crc_r <= CRC_INIT; // RULE_09
        sdaOe <= 1'b0;
        hostAck_r <= 1'b0;
      end else if (stopDet) begin
        // Partial byte is dropped by leaving it unprocessed
        state_r <= IDLE; // RULE_05
        sdaOe <= 1'b0;
      end else begin
        case (state_r)
          RX: begin
            if (sclRise && bitCnt_r < 4'd8) begin
              shift_r <= {shift_r[6:0], sdaQ};
              bitCnt_r <= bitCnt_r + 4'd1;
            end
            if (byteDone) begin
              sdaOe <= ackByte; // RULE_05
              state_r <= ackByte ? ACK : IGNORE;
              if (byteIdx_r == 3'd0) begin
                rw_r <= shift_r[0];
                crcTxn_r <= crcOn; // RULE_06
              end
              if (byteIdx_r == 3'd1) begin
                ptr_r <= shift_r;
              end
              if (byteIdx_r == 3'd2) begin
                data_r <= shift_r;
              end
              if (byteIdx_r < 3'd3) begin
                crc_r <= crcNxt; // RULE_07
              end
              if (wrNow) begin
                wrStrobe_r <= 1'b1;
                wrAddr_r <= ptr_r[PW-1:0];
                wrData_r <= crcTxn_r ? data_r : shift_r; // RULE_15
                ptr_r <= ptr_r + 8'h01;
              end
              crcFail_r <= failNow; // RULE_08
            end
          end
          ACK: begin
            if (sclFall) begin
              bitCnt_r <= 4'h0;
              byteIdx_r <= (byteIdx_r == 3'd4) ? 3'd4 : byteIdx_r + 3'd1;
              if (rw_r) begin
                tx_r <= regFile[ptr_r[PW-1:0]];
                sdaOe <= !regFile[ptr_r[PW-1:0]][7];
                state_r <= TX;
              end else begin
                sdaOe <= 1'b0;
                state_r <= RX;
              end
            end
          end
          TX: begin
            if (sclFall) begin
              if (bitCnt_r == 4'd7) begin
                sdaOe <= 1'b0;
                state_r <= TXACK;
              end else begin
                tx_r <= {tx_r[6:0], 1'b0};
                sdaOe <= !tx_r[6];
                bitCnt_r <= bitCnt_r + 4'd1;
              end
            end
          end
          TXACK: begin
            if (sclRise) begin
              if (sdaQ) begin
                state_r <= IGNORE;
              end else begin
                hostAck_r <= 1'b1;
                ptr_r <= ptr_r + 8'h01;
              end
            end
            if (sclFall && hostAck_r) begin
              hostAck_r <= 1'b0;
              bitCnt_r <= 4'h0;
              tx_r <= regFile[ptr_r[PW-1:0]];
              sdaOe <= !regFile[ptr_r[PW-1:0]][7];
              state_r <= TX;
            end
          end
          IDLE, IGNORE: begin
            sdaOe <= 1'b0;
          end
          default: begin
            state_r <= IDLE;
            sdaOe <= 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        regFile[i] <= 8'h00;
      end
    end else if (wrStrobe_r) begin
      regFile[wrAddr_r] <= wrData_r;
    end
  end

  // Wishbone slave: one wait state, ack drops the cycle after
  assign wbAccept = wbCyc && wbStb && !wbAck;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wbAck <= 1'b0;
    end else begin
      wbAck <= wbAccept;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_r <= CTRL_RESET;
      mask_r <= MASK_RESET;
    end else if (wbAccept && wbReq.we && wbReq.sel[0]) begin
      if (wbReq.adr == OFS_CTRL) begin
        ctrl_r <= wbReq.dat[7:0] & 8'h71;
      end
      if (wbReq.adr == OFS_MASK) begin
        mask_r <= wbReq.dat[STATUS_W-1:0];
      end
    end
  end

  // Sticky flags; a new event beats a simultaneous clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      status_r <= '0;
    end else begin
      for (int i = 0; i < STATUS_W; i++) begin
        if ((i == ST_CRC_FAULT && crcFail_r) || (i == ST_WRITE_DONE && wrStrobe_r)) begin
          status_r[i] <= 1'b1; // RULE_08
        end else if (wbAccept && wbReq.we && wbReq.sel[0] && wbReq.adr == OFS_STATUS
                     && wbReq.dat[i]) begin
          status_r[i] <= 1'b0; // RULE_14
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq <= 1'b0;
      interruptRequestN <= 1'b1;
    end else begin
      irq <= |(status_r & mask_r); // RULE_14
      interruptRequestN <= !(|(status_r & mask_r)); // RULE_08
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wbDatR <= 32'h0000_0000;
    end else if (wbAccept) begin
      wbDatR <= 32'h0000_0000;
      if (wbReq.adr == OFS_CTRL) begin
        wbDatR[7:0] <= ctrl_r;
      end else if (wbReq.adr == OFS_STATUS) begin
        wbDatR[STATUS_W-1:0] <= status_r;
      end else if (wbReq.adr == OFS_MASK) begin
        wbDatR[STATUS_W-1:0] <= mask_r;
      end else if (wbReq.adr == OFS_STATE) begin
        wbDatR[9:0] <= {progMode, state_r != IDLE, crcOn, devAddr};
      end else if (wbReq.adr >= OFS_FILE && wbReq.adr[1:0] == 2'b00
                   && wbReq.adr < OFS_FILE + 8'(4 * FILE_DEPTH)) begin
        wbDatR[7:0] <= regFile[wbReq.adr[2 +: PW]];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_target_only;
    (state_r == IDLE || state_r == IGNORE) |=> !sdaOe;
  endproperty
  a_target_only: assert property (p_target_only) else $error("SDA driven outside a transfer"); // RULE_01

  property p_addr_cfg;
    !progMode |-> devAddr == 7'h08 + {4'h0, ctrl_r[6:4]};
  endproperty
  a_addr_cfg: assert property (p_addr_cfg) else $error("Configured address wrong"); // RULE_02

  property p_addr_fixed;
    progMode |-> devAddr == 7'h08;
  endproperty
  a_addr_fixed: assert property (p_addr_fixed) else $error("Programming address not fixed"); // RULE_11

  property p_ack_after8;
    (state_r == ACK && $past(state_r) == RX) |-> $past(bitCnt_r) == 4'd8 && sdaOe;
  endproperty
  a_ack_after8: assert property (p_ack_after8) else $error("Acknowledge before eighth bit"); // RULE_04

  sequence s_short_stop;
    stopDet && state_r == RX && bitCnt_r < 4'd8;
  endsequence
  property p_short_no_ack;
    s_short_stop |=> state_r == IDLE && !sdaOe && !wrStrobe_r ##1 !sdaOe;
  endproperty
  a_short_no_ack: assert property (p_short_no_ack) else $error("Short transfer acted on"); // RULE_05

  property p_crc_reject;
    crcFail_r |-> !wrStrobe_r ##1 status_r[ST_CRC_FAULT];
  endproperty
  a_crc_reject: assert property (p_crc_reject) else $error("CRC failure not handled"); // RULE_08

  property p_crc_gate;
    (wrStrobe_r && crcTxn_r) |-> $past(byteIdx_r) == 3'd3 && $past(shift_r) == $past(crc_r);
  endproperty
  a_crc_gate: assert property (p_crc_gate) else $error("Checked write without match"); // RULE_15

  property p_crc_preset;
    startDet |=> crc_r == 8'hff;
  endproperty
  a_crc_preset: assert property (p_crc_preset) else $error("CRC not preset"); // RULE_09

  property p_bypass;
    (progMode && !powerUp) |-> !crcOn ##1 secureWriteBypass;
  endproperty
  a_bypass: assert property (p_bypass) else $error("Programming bypass missing"); // RULE_12

  property p_wd_stop;
    $rose(progMode) |=> watchdogStop && configurationProgrammingMode;
  endproperty
  a_wd_stop: assert property (p_wd_stop) else $error("Watchdog not stopped"); // RULE_13

  property p_irq_hold;
    (status_r[ST_CRC_FAULT] && mask_r[ST_CRC_FAULT]) [*2] |-> irq && !interruptRequestN;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("Interrupt not held"); // RULE_14
endmodule
`default_nettype wire

/* tb/i2c_host_model.sv */
// Behavioural I2C bus controller that drives the target's serial pins.
// Assumes an open-drain SDA with pull-up resolved by the bench.
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model #(
  parameter int HALF_NS = 148
) (
  output logic scl,
  output logic sdaOe,
  input wire logic sda
);
  // SCL rests high between frames
  initial begin
    scl = 1'h1;
    sdaOe = 1'h0;
  end
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    c ^= d;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? {c[6:0], 1'h0} ^ 8'h1d : {c[6:0], 1'h0};
    end
    return c;
  endfunction
  task automatic start();
    sdaOe = 1'h1;
    #(HALF_NS) scl = 1'h0;
  endtask
  task automatic stop();
    #(HALF_NS/2) sdaOe = 1'h1;
    #(HALF_NS/2) scl = 1'h1;
    #(HALF_NS/2) sdaOe = 1'h0;
    #(HALF_NS);
  endtask
  // Sends the top n bits MSB first; ack slot only for a whole byte
  task automatic bits(input logic [7:0] b, input int n, output logic ack);
    ack = 1'h0;
    for (int i = 7; i > 7 - n; i--) begin
      #(HALF_NS/2) sdaOe = !b[i];
      #(HALF_NS/2) scl = 1'h1;
      #(HALF_NS) scl = 1'h0;
    end
    if (n == 8) begin
      #(HALF_NS/2) sdaOe = 1'h0;
      #(HALF_NS/2) scl = 1'h1;
      #(HALF_NS/2) ack = !sda;
      #(HALF_NS/2) scl = 1'h0;
    end
  endtask
  // Mode 0 plain, 1 good check byte, 2 corrupted check byte
  task automatic write(input logic [7:0] b[$], input int mode, output int nacks);
    logic [7:0] c;
    logic a;
    c = 8'hff;
    nacks = 0;
    foreach (b[i]) c = crc8(c, b[i]);
    if (mode != 0) b.push_back(mode == 1 ? c : ~c);
    start();
    foreach (b[i]) begin
      bits(b[i], 8, a);
      nacks += !a;
    end
    stop();
  endtask
endmodule
`default_nettype wire

/* tb/tb_pmic_i2c_target_crc_check.sv */
// Self-checking bench for the CRC-checked I2C target.
// Assumes the host model on the serial pins and Wishbone register access.
`timescale 1ns/1ns
`default_nettype none
module tb_pmic_i2c_target_crc_check import i2c_target_pkg::*; ;
  logic clk, nrst, wbCyc, wbStb, programmingModePin, powerUpEvent;
  wb_req_t wbReq;
  logic [31:0] wbDatR, rd;
  logic wbAck, sdaOut, sdaOe, irq, interruptRequestN, hostScl, hostOe, ack;
  logic configurationProgrammingMode, watchdogStop, secureWriteBypass;
  wire sdaLine;
  i2c_pins_t pins;
  int failCount, comparisons, oeCycles, nacks;
  // Pull-up: released wire reads high
  assign sdaLine = !(sdaOe | hostOe);
  assign pins = '{scl: hostScl, sda: sdaLine};
  i2c_target_crc #(.FILE_DEPTH(16)) DUT (.clk(clk), .nrst(nrst), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbReq(wbReq), .wbDatR(wbDatR), .wbAck(wbAck), .pinsIn(pins),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .programmingModePin(programmingModePin),
    .powerUpEvent(powerUpEvent), .irq(irq), .interruptRequestN(interruptRequestN),
    .configurationProgrammingMode(configurationProgrammingMode),
    .watchdogStop(watchdogStop), .secureWriteBypass(secureWriteBypass));
  i2c_host_model #(.HALF_NS(148)) host (.scl(hostScl), .sdaOe(hostOe), .sda(sdaLine));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (sdaOe === 1'h1) oeCycles++;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failCount++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wbCyc <= 1'h1;
    wbStb <= 1'h1;
    wbReq <= '{adr: a, dat: d, sel: 4'hf, we: we};
    do @(posedge clk); while (wbAck !== 1'h1);
    rd = wbDatR;
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'h0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic endOfTest();
    $display("comparisons=%0d mismatches=%0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic t_reset();
    rdchk(OFS_CTRL, 32'h0);
    rdchk(OFS_MASK, 32'h0);
    rdchk(OFS_STATE, {25'h0, ADDR_BASE});
    check(interruptRequestN, 1'h1);
    check(sdaOut, 1'h0);
    wb(1'h1, 8'h80, 32'hffff_ffff);
    rdchk(8'h80, 32'h0);
  endtask
  task automatic t_plain();
    wb(1'h1, OFS_CTRL, 32'h50);
    rdchk(OFS_STATE, 32'h0d);
    host.write({8'h1a, 8'h03, 8'ha5}, 0, nacks);
    check(nacks, 0);
    rdchk(OFS_FILE + 8'h0c, 32'ha5);
    host.write({8'h10, 8'h04, 8'h11}, 0, nacks);
    check(nacks, 3);
    rdchk(OFS_FILE + 8'h10, 32'h0);
    oeCycles = 0;
    host.start();
    host.bits(8'h1a, 7, ack);
    host.stop();
    check(oeCycles, 0);
    // Two whole bytes after the address, then a five-bit tail
    host.start();
    host.bits(8'h1a, 8, ack);
    host.bits(8'h05, 8, ack);
    host.bits(8'h3c, 8, ack);
    host.bits(8'h77, 5, ack);
    host.stop();
    rdchk(OFS_FILE + 8'h14, 32'h3c);
    rdchk(OFS_FILE + 8'h18, 32'h0);
  endtask
  task automatic t_crc();
    wb(1'h1, OFS_CTRL, 32'h51);
    rdchk(OFS_STATE, 32'h8d);
    host.write({8'h1a, 8'h09, 8'hc3}, 0, nacks);
    rdchk(OFS_FILE + 8'h24, 32'h0);
    wb(1'h1, OFS_STATUS, 32'h3);
    host.write({8'h1a, 8'h09, 8'hc3}, 1, nacks);
    rdchk(OFS_FILE + 8'h24, 32'hc3);
    rdchk(OFS_STATUS, 32'h2);
    host.write({8'h1a, 8'h0a, 8'h66}, 2, nacks);
    rdchk(OFS_FILE + 8'h28, 32'h0);
    rdchk(OFS_STATUS, 32'h3);
    check(irq, 1'h0);
    wb(1'h1, OFS_MASK, 32'h1);
    cyc(2);
    check(interruptRequestN, 1'h0);
    // Clearing the other flag must leave the line asserted
    wb(1'h1, OFS_STATUS, 32'h2);
    cyc(2);
    check(irq, 1'h1);
    wb(1'h1, OFS_STATUS, 32'h1);
    cyc(2);
    check({irq, interruptRequestN}, 2'h1);
  endtask
  task automatic t_prog();
    programmingModePin <= 1'h1;
    cyc(6);
    check({configurationProgrammingMode, watchdogStop, secureWriteBypass}, 3'h7);
    rdchk(OFS_STATE, 32'h208);
    host.write({8'h10, 8'h07, 8'h5a}, 0, nacks);
    check(nacks, 0);
    rdchk(OFS_FILE + 8'h1c, 32'h5a);
    powerUpEvent <= 1'h1;
    cyc(6);
    check({watchdogStop, secureWriteBypass}, 2'h2);
    programmingModePin <= 1'h0;
    cyc(6);
    check({configurationProgrammingMode, watchdogStop}, 2'h0);
  endtask
  initial begin
    #500000;
    failCount++;
    endOfTest();
  end
  initial begin
    nrst = 1'h0;
    wbCyc = 1'h0;
    wbStb = 1'h0;
    wbReq = '0;
    programmingModePin = 1'h0;
    powerUpEvent = 1'h0;
    failCount = 0;
    comparisons = 0;
    oeCycles = 0;
    // Three edges so the pin synchronisers clear too
    cyc(3);
    nrst <= 1'h1;
    t_reset();
    t_plain();
    t_crc();
    t_prog();
    endOfTest();
  end
endmodule
`default_nettype wire
